// File: verilog/char_codec_pkg.sv
/*
 * Shared constants and carrier types for the seven-bit character codec.
 * Assumes nothing beyond a SystemVerilog-capable tool chain.
 */
package char_codec_pkg;

  // ==========================================================
  // character layout
  // ==========================================================
  localparam int          CODE_W        = 6;
  localparam int          CHAR_W        = 7;
  localparam int          PARITY_POS    = 6;
  localparam logic [3:0]  EXCESS_OFFSET = 4'h3;
  localparam logic [3:0]  DIGIT_MAX     = 4'h9;
  localparam logic [1:0]  ZONE_DIGIT    = 2'h0;
  localparam logic [5:0]  ZERO_CODE     = 6'h03;
  localparam logic [6:0]  IGNORE_CODE   = 7'h40;
  localparam logic [6:0]  SPACE_CODE    = 7'h01;

  // ==========================================================
  // word layout
  // ==========================================================
  localparam int          WORD_CHARS    = 12;
  localparam int          OP_CHARS      = 3;
  localparam int          SIGN_POS      = 0;
  localparam int          MSC_POS       = 11;
  localparam logic [3:0]  CHAR_CNT_LAST = 4'hB;
  localparam logic [3:0]  NORM_MAX      = 4'hA;
  localparam logic [3:0]  CNT_RESET     = 4'h0;
  localparam logic [1:0]  RST_SYNC_INIT = 2'h0;

  typedef struct packed {
    logic       parity;
    logic [1:0] zone;
    logic [3:0] digit;
  } char_type;

  typedef char_type [WORD_CHARS-1:0] word_type;

  typedef struct packed {
    logic parity_err;
    logic is_ignore;
    logic is_space;
    logic is_digit;
  } status_type;

  typedef enum logic [1:0] {
    NORM_IDLE  = 2'b00,
    NORM_SHIFT = 2'b01,
    NORM_DONE  = 2'b10
  } norm_state_type;

endpackage

// File: verilog/char_classify.sv
/*
 * Combinational parity generator and character classifier.
 * Assumes the caller registers the results; no state is held here.
 */
`timescale 1ns/1ns
module char_classify
(
  input  wire logic [char_codec_pkg::CODE_W-1:0] i_code,
  input  wire char_codec_pkg::char_type          i_char,
  output logic                                   o_parity,
  output char_codec_pkg::status_type             o_status
);

  // ==========================================================
  // parity and class
  // ==========================================================
  always_comb
  begin
    o_parity            = ~(^i_code);                                        // [R1]
    o_status.parity_err = ~(^i_char);                                        // [R2]
    o_status.is_ignore  = (i_char == char_codec_pkg::IGNORE_CODE);           // [R5]
    o_status.is_space   = (i_char == char_codec_pkg::SPACE_CODE);            // [R6]
    o_status.is_digit   = (i_char.zone == char_codec_pkg::ZONE_DIGIT)        // [R4]
                          && (i_char.digit >= char_codec_pkg::EXCESS_OFFSET)
                          && (i_char.digit <= char_codec_pkg::DIGIT_MAX + char_codec_pkg::EXCESS_OFFSET);
  end

endmodule

// File: verilog/char_codec.sv
/*
 * Character codec: parity generation, transfer check, digit encoding,
 * twelve-character word assembly, masked compare and normalisation.
 * Assumes all data inputs come from logic on I_CORE_CLK.
 */
// Summary of operation
// R1: each six-bit code gets parity bit one on even ones, zero on odd.
// R2: seven-bit transfer characters with even ones count raise parity error.
// R3: decimal digits encode as four bits holding digit plus three.
// R4: two zero zone bits extend the digit into a six-bit code.
// R5: character 1000000 is the ignore code and suppresses comparison there.
// R6: character 0000001 is the space code, a blank position.
// R7: arithmetic and logical data travel as twelve-character words.
// R8: instruction words are twelve characters long.
// R9: operation code is the three right-most, lowest-order characters.
// R10: sign sits in the lowest character; others most significant at left.
// R11: normalising shifts left one character until top position is significant.
// R12: mnemonic and numeric op codes decode alike through their low four bits.
// R13: one character per clock; reset clears any pending parity error.
`timescale 1ns/1ns
module char_codec
(
  input  wire logic                                                  I_CORE_CLK,
  input  wire logic                                                  I_RST_N,
  input  wire logic                                                  I_CE,
  input  wire logic                                                  I_ENC_VALID,
  input  wire logic                                                  I_ENC_IS_DIGIT,
  input  wire logic [char_codec_pkg::CODE_W-1:0]                     I_ENC_CODE,
  input  wire logic                                                  I_XFER_VALID,
  input  wire char_codec_pkg::char_type                              I_XFER_CHAR,
  input  wire logic                                                  I_ERR_CLR,
  input  wire char_codec_pkg::word_type                              I_CMP_WORD,
  input  wire logic                                                  I_NORM_START,
  output logic                                                       O_ENC_VALID,
  output char_codec_pkg::char_type                                   O_ENC_CHAR,
  output logic                                                       O_ENC_RANGE_ERR,
  output logic                                                       O_CHK_VALID,
  output char_codec_pkg::status_type                                 O_CHK_STATUS,
  output logic                                                       O_PARITY_ERR,
  output logic                                                       O_WORD_VALID,
  output char_codec_pkg::word_type                                   O_WORD,
  output logic [char_codec_pkg::OP_CHARS*4-1:0]                      O_OP_KEY,
  output char_codec_pkg::char_type                                   O_SIGN,
  output logic                                                       O_CMP_EQUAL,
  output logic                                                       O_NORM_BUSY,
  output logic                                                       O_NORM_VALID,
  output char_codec_pkg::word_type                                   O_NORM_WORD,
  output logic [3:0]                                                 O_NORM_SHIFTS
);

  // ==========================================================
  // reset release
  // ==========================================================
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  // assert at once, release two clocks later so all flops leave reset together
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      rst_sync_reg <= char_codec_pkg::RST_SYNC_INIT;
    else if (I_CE)
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  assign rst_n = rst_sync_reg[1];

  // ==========================================================
  // encode path
  // ==========================================================
  logic [char_codec_pkg::CODE_W-1:0] enc_code;
  logic                              enc_parity;
  logic                              enc_bad;
  char_codec_pkg::status_type        enc_status_unused;

  always_comb
  begin
    enc_bad  = 1'b0;
    enc_code = I_ENC_CODE;
    if (I_ENC_IS_DIGIT)
    begin
      enc_bad  = (I_ENC_CODE[3:0] > char_codec_pkg::DIGIT_MAX);
      enc_code = {char_codec_pkg::ZONE_DIGIT,                                // [R4]
                  I_ENC_CODE[3:0] + char_codec_pkg::EXCESS_OFFSET};          // [R3]
    end
  end

  char_classify u_enc_classify
  (
    .i_code   (enc_code),
    .i_char   ({1'b0, enc_code}),
    .o_parity (enc_parity),
    .o_status (enc_status_unused)
  );

  always_ff @(posedge I_CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      O_ENC_VALID     <= 1'b0;
      O_ENC_CHAR      <= '0;
      O_ENC_RANGE_ERR <= 1'b0;
    end
    else if (I_CE)
    begin
      O_ENC_VALID     <= I_ENC_VALID;
      O_ENC_RANGE_ERR <= I_ENC_VALID & enc_bad;
      if (I_ENC_VALID)
        O_ENC_CHAR <= {enc_parity, enc_code};                                // [R1]
    end
  end

  // ==========================================================
  // transfer check
  // ==========================================================
  char_codec_pkg::status_type xfer_status;
  logic                       xfer_parity_unused;

  char_classify u_xfer_classify
  (
    .i_code   (I_XFER_CHAR[char_codec_pkg::CODE_W-1:0]),
    .i_char   (I_XFER_CHAR),
    .o_parity (xfer_parity_unused),
    .o_status (xfer_status)
  );

  always_ff @(posedge I_CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      O_CHK_VALID  <= 1'b0;
      O_CHK_STATUS <= '0;
    end
    else if (I_CE)
    begin
      O_CHK_VALID <= I_XFER_VALID;                                           // [R13]
      if (I_XFER_VALID)
        O_CHK_STATUS <= xfer_status;                                         // [R2]
    end
  end

  // sticky error: a new error in the clearing cycle wins over the clear
  always_ff @(posedge I_CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
      O_PARITY_ERR <= 1'b0;                                                  // [R13]
    else if (I_CE)
    begin
      if (I_XFER_VALID && xfer_status.parity_err)
        O_PARITY_ERR <= 1'b1;                                                // [R2]
      else if (I_ERR_CLR)
        O_PARITY_ERR <= 1'b0;
    end
  end

  // ==========================================================
  // word assembly
  // ==========================================================
  // first character in is the most significant; the twelfth is the sign
  char_codec_pkg::word_type asm_reg;
  char_codec_pkg::word_type asm_next;
  logic [3:0]               char_cnt_reg;
  logic                     word_done;

  assign asm_next  = {asm_reg[char_codec_pkg::MSC_POS-1:0], I_XFER_CHAR};    // [R10]
  assign word_done = I_XFER_VALID && (char_cnt_reg == char_codec_pkg::CHAR_CNT_LAST);

  always_ff @(posedge I_CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      asm_reg      <= '0;
      char_cnt_reg <= char_codec_pkg::CNT_RESET;
    end
    else if (I_CE && I_XFER_VALID)
    begin
      asm_reg <= asm_next;
      if (word_done)
        char_cnt_reg <= char_codec_pkg::CNT_RESET;                           // [R7]
      else
        char_cnt_reg <= char_cnt_reg + 4'h1;
    end
  end

  logic [char_codec_pkg::OP_CHARS*4-1:0] op_key;

  // low four bits only, so letter and numeric op codes meet the same key
  genvar op_i;
  generate
    for (op_i = 0; op_i < char_codec_pkg::OP_CHARS; op_i++)
    begin : g_op
      assign op_key[op_i*4 +: 4] = asm_next[op_i].digit;                    // [R9] [R12]
    end
  endgenerate

  always_ff @(posedge I_CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      O_WORD_VALID <= 1'b0;
      O_WORD       <= '0;
      O_OP_KEY     <= '0;
      O_SIGN       <= '0;
    end
    else if (I_CE)
    begin
      O_WORD_VALID <= word_done;                                             // [R8]
      if (word_done)
      begin
        O_WORD   <= asm_next;                                                // [R7]
        O_OP_KEY <= op_key;                                                  // [R9]
        O_SIGN   <= asm_next[char_codec_pkg::SIGN_POS];                      // [R10]
      end
    end
  end

  // ==========================================================
  // masked compare
  // ==========================================================
  logic [char_codec_pkg::WORD_CHARS-1:0] pos_match;

  genvar cmp_i;
  generate
    for (cmp_i = 0; cmp_i < char_codec_pkg::WORD_CHARS; cmp_i++)
    begin : g_cmp
      assign pos_match[cmp_i] = (O_WORD[cmp_i] == I_CMP_WORD[cmp_i])
                                || (O_WORD[cmp_i] == char_codec_pkg::IGNORE_CODE)      // [R5]
                                || (I_CMP_WORD[cmp_i] == char_codec_pkg::IGNORE_CODE); // [R5]
    end
  endgenerate

  always_ff @(posedge I_CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
      O_CMP_EQUAL <= 1'b0;
    else if (I_CE)
      O_CMP_EQUAL <= &pos_match;
  end

  // ==========================================================
  // normaliser
  // ==========================================================
  // sign stays put; the magnitude moves left with zero codes fed in behind
  char_codec_pkg::norm_state_type state_reg;
  char_codec_pkg::norm_state_type state_next;
  logic                           top_is_zero;

  assign top_is_zero = (O_NORM_WORD[char_codec_pkg::MSC_POS][char_codec_pkg::CODE_W-1:0]
                        == char_codec_pkg::ZERO_CODE);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      char_codec_pkg::NORM_IDLE:
        if (I_NORM_START)
          state_next = char_codec_pkg::NORM_SHIFT;
      char_codec_pkg::NORM_SHIFT:
        if (!top_is_zero || (O_NORM_SHIFTS == char_codec_pkg::NORM_MAX))
          state_next = char_codec_pkg::NORM_DONE;
      char_codec_pkg::NORM_DONE:
        state_next = char_codec_pkg::NORM_IDLE;
      default:
        state_next = char_codec_pkg::NORM_IDLE;
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= char_codec_pkg::NORM_IDLE;
    else if (I_CE)
      state_reg <= state_next;
  end

  always_ff @(posedge I_CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      O_NORM_WORD   <= '0;
      O_NORM_SHIFTS <= char_codec_pkg::CNT_RESET;
    end
    else if (I_CE)
    begin
      if (state_reg == char_codec_pkg::NORM_IDLE && I_NORM_START)
      begin
        O_NORM_WORD   <= O_WORD;
        O_NORM_SHIFTS <= char_codec_pkg::CNT_RESET;
      end
      else if (state_reg == char_codec_pkg::NORM_SHIFT && state_next == char_codec_pkg::NORM_SHIFT)
      begin
        O_NORM_WORD[char_codec_pkg::MSC_POS:2] <= O_NORM_WORD[char_codec_pkg::MSC_POS-1:1];  // [R11]
        O_NORM_WORD[1]                         <= {~^char_codec_pkg::ZERO_CODE, char_codec_pkg::ZERO_CODE}; // [R1]
        O_NORM_SHIFTS                          <= O_NORM_SHIFTS + 4'h1;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      O_NORM_BUSY  <= 1'b0;
      O_NORM_VALID <= 1'b0;
    end
    else if (I_CE)
    begin
      O_NORM_BUSY  <= (state_next != char_codec_pkg::NORM_IDLE);
      O_NORM_VALID <= (state_next == char_codec_pkg::NORM_DONE);
    end
  end

endmodule

// File: dv/char_codec_properties.sv
/* Concurrent checks on the character codec ports.
   Assumes binding to char_codec, one clock domain, I_CE mostly high. */
`timescale 1ns/1ns
module char_codec_properties
(
  input wire logic                          I_CORE_CLK,
  input wire logic                          I_RST_N,
  input wire logic                          I_CE,
  input wire logic                          I_ENC_VALID,
  input wire logic                          I_ENC_IS_DIGIT,
  input wire logic [char_codec_pkg::CODE_W-1:0] I_ENC_CODE,
  input wire logic                          I_XFER_VALID,
  input wire char_codec_pkg::char_type      I_XFER_CHAR,
  input wire logic                          I_ERR_CLR,
  input wire logic                          I_NORM_START,
  input wire logic                          O_ENC_VALID,
  input wire char_codec_pkg::char_type      O_ENC_CHAR,
  input wire logic                          O_PARITY_ERR,
  input wire logic                          O_WORD_VALID,
  input wire char_codec_pkg::word_type      O_WORD,
  input wire logic [char_codec_pkg::OP_CHARS*4-1:0] O_OP_KEY,
  input wire char_codec_pkg::char_type      O_SIGN,
  input wire logic                          O_NORM_BUSY,
  input wire logic                          O_NORM_VALID
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  // ==========================================================
  // character position counter
  // ==========================================================
  logic [3:0] n_reg;
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      n_reg <= 4'h0;
    else if (I_CE && I_XFER_VALID)
      n_reg <= (n_reg == 4'hB) ? 4'h0 : n_reg + 4'h1;
  end
  // ==========================================================
  // properties
  // ==========================================================
  sequence s_start;
    I_CE && I_NORM_START && !O_NORM_BUSY && !O_NORM_VALID;
  endsequence
  sequence s_result;
    ##[2:12] O_NORM_VALID;
  endsequence
  chk_enc_answer: assert property (I_CE && I_ENC_VALID |=> O_ENC_VALID)
    else $error("encode answer missing");
  chk_enc_parity: assert property (O_ENC_VALID |-> O_ENC_CHAR.parity == !(^O_ENC_CHAR[5:0]))
    else $error("encode parity bit wrong");
  chk_digit_code: assert property (I_CE && I_ENC_VALID && I_ENC_IS_DIGIT |=>
    O_ENC_CHAR[5:0] == {2'b00, $past(I_ENC_CODE[3:0]) + 4'h3})
    else $error("digit code wrong");
  chk_xfer_err: assert property (I_CE && I_XFER_VALID && !(^I_XFER_CHAR) |=> O_PARITY_ERR)
    else $error("even ones not flagged");
  chk_err_hold: assert property (O_PARITY_ERR && !I_ERR_CLR |=> O_PARITY_ERR)
    else $error("parity error dropped");
  chk_word_count: assert property (I_CE && I_XFER_VALID && n_reg == 4'hB |=> O_WORD_VALID)
    else $error("word not complete at twelve");
  chk_word_only: assert property (O_WORD_VALID |-> n_reg == 4'h0 && $past(I_XFER_VALID))
    else $error("word valid out of step");
  chk_sign_pos: assert property (O_WORD_VALID |-> O_SIGN == O_WORD[0])
    else $error("sign not lowest char");
  chk_op_key: assert property (O_WORD_VALID |->
    O_OP_KEY == {O_WORD[2].digit, O_WORD[1].digit, O_WORD[0].digit})
    else $error("operation key wrong");
  chk_norm_bound: assert property (s_start |-> s_result)
    else $error("normalise too slow");
endmodule

bind char_codec char_codec_properties chk
(
  .I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_CE(I_CE), .I_ENC_VALID(I_ENC_VALID),
  .I_ENC_IS_DIGIT(I_ENC_IS_DIGIT), .I_ENC_CODE(I_ENC_CODE), .I_XFER_VALID(I_XFER_VALID),
  .I_XFER_CHAR(I_XFER_CHAR), .I_ERR_CLR(I_ERR_CLR), .I_NORM_START(I_NORM_START),
  .O_ENC_VALID(O_ENC_VALID), .O_ENC_CHAR(O_ENC_CHAR), .O_PARITY_ERR(O_PARITY_ERR),
  .O_WORD_VALID(O_WORD_VALID), .O_WORD(O_WORD), .O_OP_KEY(O_OP_KEY), .O_SIGN(O_SIGN),
  .O_NORM_BUSY(O_NORM_BUSY), .O_NORM_VALID(O_NORM_VALID)
);

// File: dv/char_source.sv
/* Model of the transfer path that feeds characters to the codec.
   Assumes i_start is a one-cycle pulse while no word is in flight. */
`timescale 1ns/1ns
module char_source
(
  input  wire logic                     i_clk,
  input  wire logic                     i_start,
  input  wire logic [3:0]               i_bad_idx,
  input  wire char_codec_pkg::word_type i_payload,
  output logic                          o_valid,
  output char_codec_pkg::char_type      o_char
);
  logic [3:0]               left_reg;
  logic [3:0]               cnt;
  char_codec_pkg::char_type c;
  initial
  begin
    left_reg = 4'h0;
    o_valid = 1'b0;
    o_char = '0;
  end
  // ==========================================================
  // most significant character first, one per clock
  // ==========================================================
  always @(posedge i_clk)
  begin
    cnt = i_start ? 4'hC : left_reg;
    o_valid <= (cnt != 4'h0);
    if (cnt != 4'h0)
    begin
      c = i_payload[cnt - 4'h1];
      // odd total unless told to break it at one position
      c.parity = ~^c[5:0] ^ ((cnt - 4'h1) == i_bad_idx);
      o_char <= c;
      left_reg <= cnt - 4'h1;
    end
    else
      o_char <= ~o_char; // idle line must not look like a held character
  end
endmodule

// File: dv/char_codec_tb.sv
/* Self-checking bench for the character codec.
   Assumes the bound checker and the char_source model. */
`timescale 1ns/1ns
module char_codec_tb;
  logic clk, rst_n, ce, enc_valid, enc_is_digit, err_clr, norm_start, src_start, xfer_valid;
  logic enc_ok, enc_range, chk_ok, par_err, word_ok, cmp_eq, norm_busy, norm_ok;
  logic [5:0]                 enc_code;
  logic [3:0]                 bad_idx, norm_shifts;
  logic [11:0]                op_key;
  char_codec_pkg::char_type   xfer_char, enc_char, sign;
  char_codec_pkg::status_type status;
  char_codec_pkg::word_type   payload, cmp_word, word, norm_word;
  int                         failures;
  int                         samples_checked;

  always #50 clk = ~clk;

  char_source src (.i_clk(clk), .i_start(src_start), .i_bad_idx(bad_idx), .i_payload(payload),
    .o_valid(xfer_valid), .o_char(xfer_char));
  char_codec DUT (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_ENC_VALID(enc_valid),
    .I_ENC_IS_DIGIT(enc_is_digit), .I_ENC_CODE(enc_code), .I_XFER_VALID(xfer_valid),
    .I_XFER_CHAR(xfer_char), .I_ERR_CLR(err_clr), .I_CMP_WORD(cmp_word), .I_NORM_START(norm_start),
    .O_ENC_VALID(enc_ok), .O_ENC_CHAR(enc_char), .O_ENC_RANGE_ERR(enc_range), .O_CHK_VALID(chk_ok),
    .O_CHK_STATUS(status), .O_PARITY_ERR(par_err), .O_WORD_VALID(word_ok), .O_WORD(word),
    .O_OP_KEY(op_key), .O_SIGN(sign), .O_CMP_EQUAL(cmp_eq), .O_NORM_BUSY(norm_busy),
    .O_NORM_VALID(norm_ok), .O_NORM_WORD(norm_word), .O_NORM_SHIFTS(norm_shifts));

  // ==========================================================
  // helpers
  // ==========================================================
  task automatic check(input logic [83:0] seen, input logic [83:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic char_codec_pkg::word_type fix(char_codec_pkg::word_type p, logic [3:0] bad);
    for (int k = 0; k < 12; k++)
      p[k].parity = ~^p[k][5:0] ^ (k[3:0] == bad);
    return p;
  endfunction

  task automatic send_word(input char_codec_pkg::word_type p, input logic [3:0] bad);
    @(posedge clk);
    payload <= p;
    bad_idx <= bad;
    src_start <= 1'b1;
    @(posedge clk);
    src_start <= 1'b0;
    repeat (40)
    begin
      @(posedge clk);
      #1;
      if (word_ok === 1'b1)
        break;
    end
    check(word_ok, 1'b1);
    check(word, fix(p, bad));
  endtask

  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_encode();
    logic [7:0] e [14];
    logic [5:0] c;
    for (int i = 0; i < 14; i++)
    begin
      @(posedge clk);
      c = (i < 11) ? {2'b00, i[3:0] + 4'h3} : (i == 11) ? 6'h00 : 6'h3F;
      e[i] = {i == 10, ~^c, c};
      enc_valid <= (i < 13);
      enc_is_digit <= (i < 11);
      enc_code <= (i < 11) ? i[5:0] : c;
      #1;
      if (i > 0)
      begin
        check(enc_ok, 1'b1);
        check({enc_range, enc_char}, e[i-1]);
      end
    end
    @(posedge clk);
    #1;
    check(enc_ok, 1'b0);
    // a request held while the enable is low must wait, not be lost
    @(posedge clk);
    ce <= 1'b0;
    enc_valid <= 1'b1;
    enc_is_digit <= 1'b1;
    enc_code <= 6'h00;
    @(posedge clk);
    ce <= 1'b1;
    #1;
    check(enc_ok, 1'b0);
    @(posedge clk);
    enc_valid <= 1'b0;
    #1;
    check({enc_ok, enc_char}, 8'hC3);
    $display("t_encode done");
  endtask

  task automatic t_words();
    char_codec_pkg::word_type p, c;
    for (int k = 0; k < 12; k++)
      p[k] = {1'b0, 2'b00, k[3:0] + 4'h3};
    p[5] = 7'h40;
    p[0] = 7'h01;
    send_word(p, 4'hF);
    c = fix(p, 4'hF);
    check(sign, c[0]);
    check(op_key, {c[2].digit, c[1].digit, c[0].digit});
    check(status, 4'b0010);
    check(chk_ok, 1'b1);
    check(par_err, 1'b0);
    c[7] = 7'h40;
    c[5] = 7'h21;
    @(posedge clk);
    cmp_word <= c;
    @(posedge clk);
    #1;
    check(cmp_eq, 1'b1);
    c[3] = 7'h22;
    @(posedge clk);
    cmp_word <= c;
    @(posedge clk);
    #1;
    check(cmp_eq, 1'b0);
    $display("t_words done");
  endtask

  task automatic t_norm();
    char_codec_pkg::word_type p, e;
    int n;
    for (int k = 0; k < 12; k++)
      p[k] = {1'b0, 2'b01, k[3:0]};
    p[11] = 7'h03;
    p[10] = 7'h43;
    send_word(p, 4'hF);
    e = fix(p, 4'hF);
    for (int k = 11; k > 2; k--)
      e[k] = e[k-2];
    e[2] = 7'h43;
    e[1] = 7'h43;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      norm_start <= (k % 2 == 0);
    end
    n = 0;
    while (norm_ok !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check(n, 1);
    check(norm_busy, 1'b1);
    check(norm_shifts, 4'h2);
    check(norm_word, e);
    $display("t_norm done");
  endtask

  task automatic t_parity();
    char_codec_pkg::word_type p;
    for (int k = 0; k < 12; k++)
      p[k] = {1'b0, 6'h2A};
    send_word(p, 4'h4);
    check(par_err, 1'b1);
    @(posedge clk);
    err_clr <= 1'b1;
    @(posedge clk);
    err_clr <= 1'b0;
    #1;
    check(par_err, 1'b0);
    send_word(p, 4'h0);
    check(status[3], 1'b1);
    check(par_err, 1'b1);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check(par_err, 1'b0);
    $display("t_parity done");
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge clk);
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial
  begin
    {clk, rst_n, enc_valid, enc_is_digit, err_clr, norm_start, src_start} = '0;
    ce = 1'b1;
    enc_code = 6'h00;
    bad_idx = 4'hF;
    payload = '0;
    cmp_word = '0;
    failures = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_encode();
    t_words();
    t_norm();
    t_parity();
    end_of_test();
  end
endmodule
